//--- design/flash_cmd_config_fault_inject.sv
// Top: AXI4-Lite registers, config, command object, fault flags, interrupts.
// Assumes a phrase-wide array behind the arr_* pins and a CPU read strobe.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module flash_cmd_config_fault_inject
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cpu_rd,       // CPU array read pulse
	input  wire logic        mode_ok,      // Command available in mode
	output logic             arr_req,
	output logic [17:0]      arr_addr,
	output logic             arr_info,
	input  wire logic        arr_ack,
	input  wire logic [63:0] arr_data,
	input  wire logic        arr_sbe,
	input  wire logic        arr_dbe,
	output logic             irq           // Level interrupt
);
	flash_array_if           aif();
	logic [7:0]              cfg;          // Config register
	logic                    done_flag;    // Command done flag
	logic                    acc_err;      // Access error
	logic                    res_hi;       // Upper result bit
	logic                    res_lo;       // Lower result bit
	logic [2:0]              cidx;         // Command object index
	logic [2:0]              last_idx;     // Last written index
	logic [15:0]             cobj [0:5];   // Command object words
	logic [1:0]              fault;        // Double, single
	logic [1:0]              fault_ien;    // Fault irq enables
	logic [2:0]              ist;          // Sticky irq status
	logic [2:0]              ien;          // Irq enable
	logic                    have_aw;      // Write address held
	logic                    have_w;       // Write data held
	logic [7:0]              waddr;
	logic [31:0]             wdata;
	logic [3:0]              wstrb;
	logic                    wr_go;        // Write executes
	logic                    launch;       // Launch pulse
	logic                    eng_start;    // Checks passed
	logic                    eng_done;
	logic                    nb;
	logic                    ae;
	logic                    he;
	logic [63:0]             phr;
	logic                    cpu_ev;
	logic                    c_sbe;
	logic                    c_dbe;
	logic                    c_col;
	logic                    set_sf;
	logic                    set_df;
	logic [17:0]             ev_addr;
	logic [18:0]             ev_end;

	flash_cmd_engine flash_cmd_engine_inst
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (launch & eng_start),
		.code      (cobj[0][15:8]),
		.addr      (cobj[0][15:8] == flash_cmd_pkg::cmd_read_once ? {2'b00, cobj[1]} : ev_addr),
		.count     (cobj[2]),
		.arr       (aif.engine),
		.done      (eng_done),
		.not_blank (nb),
		.any_err   (ae),
		.hard_err  (he),
		.phrase    (phr)
	);

	flash_read_port flash_read_port_inst
	(
		.aclk        (aclk),
		.aresetn     (aresetn),
		.eng         (aif.array),
		.cpu_rd      (cpu_rd),
		.busy        (~done_flag),
		.arr_req     (arr_req),
		.arr_addr    (arr_addr),
		.arr_info    (arr_info),
		.arr_ack     (arr_ack),
		.arr_data    (arr_data),
		.arr_sbe     (arr_sbe),
		.arr_dbe     (arr_dbe),
		.cpu_ev      (cpu_ev),
		.cpu_sbe     (c_sbe),
		.cpu_dbe     (c_dbe),
		.cpu_collide (c_col)
	);

	// Write byte 0 mask helper, used by every register write
	function automatic logic lane0(input logic [3:0] s);
		lane0 = s[0];
	endfunction

	// Section address: code byte is high byte of word 0, addr 17:16 low
	assign ev_addr = {cobj[0][1:0], cobj[1]};
	assign ev_end  = {1'b0, ev_addr} + {cobj[2], 3'h0};

	// AXI write channel capture; address and data in either order
	assign s_axi_awready = ~have_aw & ~s_axi_bvalid;
	assign s_axi_wready  = ~have_w & ~s_axi_bvalid;
	assign wr_go         = have_aw & have_w & ~s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			have_aw      <= 1'b0;
			have_w       <= 1'b0;
			waddr        <= 8'h00;
			wdata        <= 32'h00000000;
			wstrb        <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				have_aw <= 1'b1;
				waddr   <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				have_w <= 1'b1;
				wdata  <= s_axi_wdata;
				wstrb  <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				have_aw      <= 1'b0;
				have_w       <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// Unmapped writes are accepted and dropped
	assign s_axi_bresp = 2'b00;

	// Config register, writable bits only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg <= flash_cmd_pkg::config_reset;
		else if (wr_go & lane0(wstrb) & waddr == flash_cmd_pkg::off_flash_config)
			cfg <= wdata[7:0] & flash_cmd_pkg::config_mask;
	end

	// Launch: write one to done flag while idle
	assign launch = wr_go & lane0(wstrb) & waddr == flash_cmd_pkg::off_cmd_status
		& wdata[flash_cmd_pkg::bit_cmd_done_flag] & done_flag;
	// Launch
	always_comb
	begin
		eng_start = 1'b0;
		if (cobj[0][15:8] == flash_cmd_pkg::cmd_erase_verify)
			eng_start = last_idx == flash_cmd_pkg::idx_erase_last & mode_ok
				& cobj[0][7:2] == 6'h00 & cobj[2] != 16'h0000
				& ev_addr[2:0] == flash_cmd_pkg::phrase_align
				& ev_end <= {1'b0, flash_cmd_pkg::pflash_top} + 19'h00001;
		else if (cobj[0][15:8] == flash_cmd_pkg::cmd_read_once)
			eng_start = last_idx == flash_cmd_pkg::idx_read_once_last & mode_ok
				& cobj[1] <= flash_cmd_pkg::read_once_max_index;
	end

	// Command status; protect violation never set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_flag <= 1'b1;
			acc_err   <= 1'b0;
			res_hi    <= 1'b0;
			res_lo    <= 1'b0;
		end
		else if (launch)
		begin
			acc_err   <= ~eng_start;
			done_flag <= ~eng_start;
			res_hi    <= 1'b0;
			res_lo    <= 1'b0;
		end
		else if (eng_done)
		begin
			// Result bits
			done_flag <= 1'b1;
			res_hi    <= nb | ae;
			res_lo    <= nb | he;
		end
	end

	// Command object words; writes only when idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cidx     <= 3'h0;
			last_idx <= 3'h0;
			for (int i = 0; i < 6; i++)
				cobj[i] <= 16'h0000;
		end
		else if (eng_done & cobj[0][15:8] == flash_cmd_pkg::cmd_read_once)
		begin
			// Results land as done sets
			cobj[2] <= phr[63:48];
			cobj[3] <= phr[47:32];
			cobj[4] <= phr[31:16];
			cobj[5] <= phr[15:0];
		end
		else if (wr_go & done_flag & lane0(wstrb))
		begin
			if (waddr == flash_cmd_pkg::off_cmd_index)
				cidx <= wdata[2:0];
			else if (waddr == flash_cmd_pkg::off_cmd_object & cidx < 3'h6)
			begin
				cobj[cidx] <= wdata[15:0];
				last_idx   <= cidx;
			end
		end
	end

	// Fault sources: forced, real or collision
	assign set_sf = cpu_ev & (cfg[flash_cmd_pkg::bit_force_single] | c_col
		| (c_sbe & ~cfg[flash_cmd_pkg::bit_ignore_single]));
	assign set_df = cpu_ev & (cfg[flash_cmd_pkg::bit_force_double] | c_col | c_dbe);

	// Fault flags, write-one-clear, set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault     <= 2'b00;
			fault_ien <= 2'b00;
		end
		else
		begin
			if (wr_go & lane0(wstrb) & waddr == flash_cmd_pkg::off_fault_irq_cfg)
				fault_ien <= wdata[1:0];
			if (wr_go & lane0(wstrb) & waddr == flash_cmd_pkg::off_fault_status)
				fault <= (fault & ~wdata[1:0]) | {set_df, set_sf};
			else
				fault <= fault | {set_df, set_sf};
		end
	end

	// Sticky irq status for done, single and double events
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ist <= 3'b000;
			ien <= 3'b000;
		end
		else
		begin
			if (wr_go & lane0(wstrb) & waddr == flash_cmd_pkg::off_irq_enable)
				ien <= wdata[2:0];
			if (wr_go & lane0(wstrb) & waddr == flash_cmd_pkg::off_irq_clear)
				ist <= (ist & ~wdata[2:0]) | {set_df, set_sf, eng_done};
			else
				ist <= ist | {set_df, set_sf, eng_done};
		end
	end

	// Level interrupt from flags and enables
	assign irq = (done_flag & cfg[flash_cmd_pkg::bit_cmd_done_irq_en])
		| (fault[1] & fault_ien[1]) | (fault[0] & fault_ien[0]) | |(ist & ien);

	// AXI read channel, answer one cycle after address
	assign s_axi_arready = ~s_axi_rvalid;
	assign s_axi_rresp   = 2'b00;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				flash_cmd_pkg::off_flash_config:  s_axi_rdata <= {24'h000000, cfg};
				flash_cmd_pkg::off_cmd_status:    s_axi_rdata <= {24'h000000, done_flag,
					1'b0, acc_err, 1'b0, 2'b00, res_hi, res_lo};
				flash_cmd_pkg::off_cmd_index:     s_axi_rdata <= {29'h00000000, cidx};
				flash_cmd_pkg::off_cmd_object:    s_axi_rdata <= {16'h0000,
					cidx < 3'h6 ? cobj[cidx] : 16'h0000};
				flash_cmd_pkg::off_fault_status:  s_axi_rdata <= {30'h00000000, fault};
				flash_cmd_pkg::off_fault_irq_cfg: s_axi_rdata <= {30'h00000000, fault_ien};
				flash_cmd_pkg::off_irq_status:    s_axi_rdata <= {29'h00000000, ist};
				flash_cmd_pkg::off_irq_enable:    s_axi_rdata <= {29'h00000000, ien};
				default:                          s_axi_rdata <= 32'h00000000;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

//--- design/flash_cmd_engine.sv
// Runs erase-verify and read-once commands over the array interface.
// Assumes the top only starts it while idle.
`timescale 1ns/10ps
module flash_cmd_engine
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,        // Launch pulse
	input  wire logic [7:0]  code,         // Command code
	input  wire logic [17:0] addr,         // Start address or phrase index
	input  wire logic [15:0] count,        // Phrase count
	flash_array_if.engine    arr,
	output logic             done,         // Finish pulse
	output logic             not_blank,    // Blank check failed
	output logic             any_err,      // Any read error in erase verify
	output logic             hard_err,     // Uncorrectable error in erase verify
	output logic [63:0]      phrase        // Read once data
);
	flash_cmd_pkg::cmd_state_t state;
	logic [15:0]             left;         // Phrases remaining
	// Sequencer: one phrase per array ack
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= flash_cmd_pkg::st_idle;
			left      <= 16'h0000;
			arr.req   <= 1'b0;
			arr.addr  <= 18'h00000;
			arr.info  <= 1'b0;
			done      <= 1'b0;
			not_blank <= 1'b0;
			any_err   <= 1'b0;
			hard_err  <= 1'b0;
			phrase    <= 64'h0000000000000000;
		end
		else
		begin
			done <= 1'b0;
			unique case (state)
				flash_cmd_pkg::st_idle:
				begin
					if (start)
					begin
						not_blank <= 1'b0;
						any_err   <= 1'b0;
						hard_err  <= 1'b0;
						arr.req   <= 1'b1;
						if (code == flash_cmd_pkg::cmd_read_once)
						begin
							// Info area phrase index
							arr.info <= 1'b1;
							arr.addr <= {addr[14:0], 3'h0};
							state    <= flash_cmd_pkg::st_read1;
						end
						else
						begin
							arr.info <= 1'b0;
							arr.addr <= addr;
							left     <= count;
							state    <= flash_cmd_pkg::st_verify;
						end
					end
				end
				flash_cmd_pkg::st_verify:
				begin
					if (arr.ack)
					begin
						// Blank and error tracking
						if (arr.data != 64'hFFFFFFFFFFFFFFFF)
							not_blank <= 1'b1;
						if (arr.sbe | arr.dbe)
							any_err <= 1'b1;
						if (arr.dbe)
							hard_err <= 1'b1;
						arr.addr <= arr.addr + 18'h00008;
						left     <= left - 16'h0001;
						if (left <= 16'h0001)
						begin
							arr.req <= 1'b0;
							done    <= 1'b1;
							state   <= flash_cmd_pkg::st_idle;
						end
					end
				end
				flash_cmd_pkg::st_read1:
				begin
					if (arr.ack)
					begin
						phrase  <= arr.data;
						arr.req <= 1'b0;
						done    <= 1'b1;
						state   <= flash_cmd_pkg::st_idle;
					end
				end
				default:
				begin
					arr.req <= 1'b0;
					state   <= flash_cmd_pkg::st_idle;
				end
			endcase
		end
	end
endmodule

//--- design/flash_read_port.sv
// Drives the outer array pins from the engine; CPU array reads are only checked.
// Assumes array returns ack one cycle or more after req.
`timescale 1ns/10ps
module flash_read_port
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	flash_array_if.array     eng,          // Engine side
	input  wire logic        cpu_rd,       // CPU array read pulse
	input  wire logic        busy,         // Command running
	output logic             arr_req,      // To array
	output logic [17:0]      arr_addr,     // To array
	output logic             arr_info,     // Info area select
	input  wire logic        arr_ack,      // From array
	input  wire logic [63:0] arr_data,     // From array
	input  wire logic        arr_sbe,      // From array
	input  wire logic        arr_dbe,      // From array
	output logic             cpu_ev,       // CPU read finished pulse
	output logic             cpu_sbe,      // Its single fault
	output logic             cpu_dbe,      // Its double fault
	output logic             cpu_collide   // Read during command
);
	// Engine owns the array; CPU reads are checked only
	assign arr_req  = eng.req;
	assign arr_addr = eng.addr;
	assign arr_info = eng.info;
	assign eng.ack  = arr_ack;
	assign eng.data = arr_data;
	assign eng.sbe  = arr_sbe;
	assign eng.dbe  = arr_dbe;
	// Register CPU read outcome one cycle late
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_ev      <= 1'b0;
			cpu_sbe     <= 1'b0;
			cpu_dbe     <= 1'b0;
			cpu_collide <= 1'b0;
		end
		else
		begin
			cpu_ev      <= cpu_rd;
			cpu_sbe     <= cpu_rd & arr_sbe & ~busy;
			cpu_dbe     <= cpu_rd & arr_dbe & ~busy;
			cpu_collide <= cpu_rd & busy;
		end
	end
endmodule

//--- shared/flash_array_if.sv
// Array port between the command engine and the array model/wrapper.
// Assumes one clock; request held until ack pulse.
`timescale 1ns/10ps
interface flash_array_if;
	logic        req;        // Read request level
	logic [17:0] addr;       // Phrase byte address
	logic        info;       // Select information area
	logic        ack;        // Data valid pulse
	logic [63:0] data;       // Phrase data
	logic        sbe;        // Corrected single fault
	logic        dbe;        // Uncorrectable double fault
	modport engine (output req, output addr, output info, input ack, input data,
		input sbe, input dbe);
	modport array (input req, input addr, input info, output ack, output data,
		output sbe, output dbe);
endinterface

//--- shared/flash_cmd_pkg.sv
// Constants, register map and command codes for the flash command block.
// Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
package flash_cmd_pkg;
	// Register byte offsets
	localparam logic [7:0] off_flash_config   = 8'h00;
	localparam logic [7:0] off_cmd_status     = 8'h04;
	localparam logic [7:0] off_cmd_index      = 8'h08;
	localparam logic [7:0] off_cmd_object     = 8'h0C;
	localparam logic [7:0] off_fault_status   = 8'h10;
	localparam logic [7:0] off_fault_irq_cfg  = 8'h14;
	localparam logic [7:0] off_irq_status     = 8'h18;
	localparam logic [7:0] off_irq_clear      = 8'h1C;
	localparam logic [7:0] off_irq_enable     = 8'h20;
	// Config field positions and writable mask
	localparam int         bit_cmd_done_irq_en    = 7;
	localparam int         bit_ignore_single      = 4;
	localparam int         bit_force_double       = 1;
	localparam int         bit_force_single       = 0;
	localparam logic [7:0] config_mask            = 8'h93;
	localparam logic [7:0] config_reset           = 8'h00;
	// Command status fields
	localparam int         bit_cmd_done_flag      = 7;
	localparam int         bit_access_error       = 5;
	localparam int         bit_protect_violation  = 4;
	localparam int         bit_result_hi          = 1;
	localparam int         bit_result_lo          = 0;
	// Fault fields
	localparam int         bit_double_fault       = 1;
	localparam int         bit_single_fault       = 0;
	// Command codes and object indices
	localparam logic [7:0] cmd_erase_verify       = 8'h03;
	localparam logic [7:0] cmd_read_once          = 8'h04;
	localparam logic [2:0] idx_erase_last         = 3'h2;
	localparam logic [2:0] idx_read_once_last     = 3'h1;
	localparam logic [2:0] idx_result_first       = 3'h2;
	localparam int         read_once_phrases      = 8;
	localparam logic [15:0] read_once_max_index   = 16'h0007;
	localparam logic [17:0] pflash_top            = 18'h3FFFF;
	localparam logic [2:0] phrase_align           = 3'h0;
	// Array read latency in cycles per phrase
	localparam int         array_wait             = 2;
	// Command engine states
	typedef enum logic [1:0]
	{
		st_idle   = 2'b00,
		st_check  = 2'b01,
		st_verify = 2'b10,
		st_read1  = 2'b11
	} cmd_state_t;
endpackage

//--- tb/flash_array_model.sv
// Flash array stand-in: answers phrase reads after a set wait.
// Assumes arr_req is held until arr_ack; fault pins follow bench inputs.
// Contents are never programmed here, so no word is programmed twice
`timescale 1ns/10ps
module flash_array_model
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        arr_req,
	input  wire logic [17:0] arr_addr,
	input  wire logic        blank,    // Return erased phrases
	input  wire logic [1:0]  wait_cyc, // Extra cycles before ack
	input  wire logic        inj_sbe,  // Report a single fault
	input  wire logic        inj_dbe,  // Report a double fault
	output logic             arr_ack,
	output logic [63:0]      arr_data,
	output logic             arr_sbe,
	output logic             arr_dbe
);
	logic [1:0]  cnt;  // Wait counter
	logic [63:0] junk; // Toggling filler so stale data never looks valid
	// One ack per request, after wait_cyc idle cycles
	always_ff @(posedge aclk)
	begin
		arr_ack <= 1'b0;
		junk    <= ~junk;
		if (!aresetn)
		begin
			cnt  <= 2'h0;
			junk <= 64'h0;
		end
		else if (arr_req && !arr_ack)
		begin
			cnt     <= (cnt == wait_cyc) ? 2'h0 : cnt + 2'h1;
			arr_ack <= (cnt == wait_cyc);
		end
	end
	// Patterned phrase carries its own address, so results can be traced
	assign arr_data = !arr_ack ? junk : blank ? 64'hFFFF_FFFF_FFFF_FFFF
		: {arr_addr[15:0], ~arr_addr[15:0], 32'h5A5A_C3C3};
	assign arr_sbe  = inj_sbe;
	assign arr_dbe  = inj_dbe;
endmodule

//--- tb/flash_cmd_sva.sv
// Checker for the flash command block, bound to its top module.
// Assumes one AXI transfer at a time and no read overlapping a write.
`timescale 1ns/10ps
module flash_cmd_sva
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        cpu_rd,
	input wire logic        arr_req,
	input wire logic [17:0] arr_addr,
	input wire logic        arr_info,
	input wire logic        arr_ack,
	input wire logic        irq
);
	logic [7:0] wa;    // Address of the write in flight
	logic [7:0] wd;    // Low byte of the write in flight
	logic [7:0] cfg;   // Mirror of flash_config
	logic [7:0] fien;  // Mirror of the fault irq enables
	logic [7:0] ien;   // Mirror of the event irq enables
	logic       quiet; // No write ending, no array traffic, no done irq
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Latch address and data as each channel is taken
	always_ff @(posedge aclk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			wd <= s_axi_wdata[7:0];
	end
	// Mirrors move when the response is taken, so they lag the block while bvalid stands
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg  <= 8'h00;
			fien <= 8'h00;
			ien  <= 8'h00;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			if (wa == 8'h00)
				cfg <= wd & 8'h93;
			if (wa == 8'h14)
				fien <= wd & 8'h03;
			if (wa == 8'h20)
				ien <= wd & 8'h07;
		end
	end
	assign quiet = !s_axi_bvalid && ien == 8'h00 && !arr_req && !cfg[7];
	a_cfg_readback: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 && !s_axi_bvalid
		|=> s_axi_rdata == {24'h0, cfg})
		else $error("config read differs from its four writable fields");
	a_force_single: assert property (
		quiet && cpu_rd && cfg[0] && !cfg[4] && fien[0] |-> ##2 irq)
		else $error("forced single fault raised no interrupt");
	a_force_double: assert property (
		quiet && cpu_rd && cfg[1] && fien[1] |-> ##2 irq)
		else $error("forced double fault raised no interrupt");
	a_ignore_single: assert property (
		quiet && cpu_rd && cfg == 8'h10 && fien == 8'h01 && !irq |-> ##2 !irq)
		else $error("ignored single fault still raised an interrupt");
	a_fault_late: assert property (
		quiet && cpu_rd && !irq |=> !irq)
		else $error("fault flag stored in the read cycle itself");
	a_irq_quiet: assert property (
		!s_axi_bvalid && !cfg[7] && fien == 8'h00 && ien == 8'h00 |-> !irq)
		else $error("interrupt raised with every enable off");
	a_req_steady: assert property (
		arr_req && !arr_ack |=> arr_req && $stable(arr_addr) && $stable(arr_info))
		else $error("array request dropped or moved before ack");
	a_verify_aligned: assert property (
		arr_req && !arr_info |-> arr_addr[2:0] == 3'h0)
		else $error("misaligned phrase read in the main array");
	a_once_range: assert property (
		arr_req && arr_info |-> arr_addr[17:6] == 12'h000 && arr_addr[2:0] == 3'h0)
		else $error("information read outside the eight reserved phrases");
endmodule
bind flash_cmd_config_fault_inject flash_cmd_sva flash_cmd_sva_inst (.*);

//--- tb/tb_flash_cmd_config_fault_inject.sv
// Bench: AXI4-Lite register traffic, fault injection and both commands.
// Assumes the array model and the bound checker; mode_ok is high except in the access error test.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_flash_cmd_config_fault_inject;
	logic        aclk = 1'b0, aresetn = 1'b0, cpu_rd = 1'b0, mode_ok = 1'b1, irq;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, wait_cyc = 2'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1; // Always ready for answers
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        arr_req, arr_info, arr_ack, arr_sbe, arr_dbe;
	logic        blank = 1'b0, inj_sbe = 1'b0, inj_dbe = 1'b0;
	logic [17:0] arr_addr;
	logic [63:0] arr_data;
	logic [15:0] ro [4] = '{16'h0038, 16'hFFC7, 16'h5A5A, 16'hC3C3}; // Phrase 7 words
	int          mismatches = 0, check_count = 0, cycles = 0;
	flash_cmd_config_fault_inject flash_cmd_config_fault_inject_inst (.*);
	flash_array_model flash_array_model_inst (.*);
	always #2 aclk = ~aclk;
	// Hang guard well above the few hundred cycles the tests need
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Ready is sampled mid-cycle, where it is settled, and acted on at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata  <= d;
		while (pa || pw)
		begin
			s_axi_awvalid <= pa;
			s_axi_wvalid  <= pw;
			@(negedge aclk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			@(posedge aclk);
		end
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		@(negedge aclk);
		while (!s_axi_bvalid) @(negedge aclk);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		@(negedge aclk);
		while (!s_axi_arready) @(negedge aclk);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(negedge aclk);
		while (!s_axi_rvalid) @(negedge aclk);
		d = s_axi_rdata;
		@(posedge aclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(d & m, e)
	endtask
	task automatic irq_chk(input logic e);
		@(negedge aclk);
		`CHK(irq, e)
		@(posedge aclk);
	endtask
	task automatic obj(input logic [2:0] i, input logic [15:0] v);
		wr(8'h08, {29'h0, i});
		wr(8'h0C, {16'h0, v});
	endtask
	// Flags land two edges after the read strobe, so the pulse waits them out
	task automatic pulse();
		cpu_rd <= 1'b1;
		@(posedge aclk);
		cpu_rd <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic wait_done();
		logic [31:0] d;
		d = 32'h0;
		while (d[7] !== 1'b1) rd(8'h04, d);
	endtask
	task automatic t_regs();
		rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0);
		wr(8'h00, 32'hFFFF_FFFF);
		rd_chk(8'h00, 32'hFFFF_FFFF, 32'h93);
		rd_chk(8'h04, 32'hFFFF_FFFF, 32'h80);
		rd_chk(8'h3C, 32'hFFFF_FFFF, 32'h0);
	endtask
	task automatic t_faults();
		wr(8'h14, 32'h3);
		wr(8'h00, 32'h3);
		pulse();
		rd_chk(8'h10, 32'hFF, 32'h3);
		irq_chk(1'b1);
		rd_chk(8'h00, 32'hFF, 32'h3);
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h1);
		wr(8'h10, 32'h0);
		rd_chk(8'h10, 32'hFF, 32'h2);
		wr(8'h10, 32'h2);
		irq_chk(1'b0);
		wr(8'h14, 32'h1);
		wr(8'h00, 32'h10);
		inj_sbe <= 1'b1;
		pulse();
		rd_chk(8'h10, 32'hFF, 32'h0);
		wr(8'h00, 32'h0);
		pulse();
		rd_chk(8'h10, 32'hFF, 32'h1);
		inj_sbe <= 1'b0;
		inj_dbe <= 1'b1;
		wr(8'h10, 32'h1);
		pulse();
		rd_chk(8'h10, 32'hFF, 32'h2);
		inj_dbe <= 1'b0;
		wr(8'h10, 32'h3);
		wr(8'h14, 32'h0);
	endtask
	task automatic t_erase();
		wr(8'h1C, 32'h7);
		wr(8'h00, 32'h80);
		obj(3'h0, 16'h0300);
		obj(3'h1, 16'h0000);
		obj(3'h2, 16'h0004);
		blank <= 1'b1;
		wr(8'h04, 32'h80);
		irq_chk(1'b0);
		wait_done();
		irq_chk(1'b1);
		rd_chk(8'h04, 32'hFF, 32'h80);
		blank    <= 1'b0;
		wait_cyc <= 2'h3;
		wr(8'h04, 32'h80);
		pulse();
		wr(8'h08, 32'h5);
		wait_done();
		rd_chk(8'h04, 32'hFF, 32'h83);
		rd_chk(8'h10, 32'hFF, 32'h3);
		rd_chk(8'h08, 32'h7, 32'h2);
		wr(8'h10, 32'h3);
		wr(8'h00, 32'h0);
		rd_chk(8'h18, 32'h1, 32'h1);
		wr(8'h20, 32'h1);
		irq_chk(1'b1);
		wr(8'h1C, 32'h7);
		irq_chk(1'b0);
		wr(8'h20, 32'h0);
	endtask
	task automatic t_once();
		// The bench plays a CPU outside the array, never the reserved block
		wait_cyc <= 2'h1;
		obj(3'h0, 16'h0400);
		obj(3'h1, 16'h0007);
		wr(8'h04, 32'h80);
		wait_done();
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h08, 32'(i + 2));
			rd_chk(8'h0C, 32'hFFFF, {16'h0, ro[i]});
		end
	endtask
	task automatic t_access_error();
		obj(3'h0, 16'h0300);
		obj(3'h1, 16'h0000);
		obj(3'h2, 16'h0001);
		mode_ok <= 1'b0;
		wr(8'h04, 32'h80);
		rd_chk(8'h04, 32'hA0, 32'hA0);
		mode_ok <= 1'b1;
		wr(8'h04, 32'h80);
		wait_done();
		rd_chk(8'h04, 32'h20, 32'h0);
		obj(3'h1, 16'h0003);
		obj(3'h2, 16'h0001);
		wr(8'h04, 32'h80);
		rd_chk(8'h04, 32'hA0, 32'hA0);
	endtask
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_faults();
		t_erase();
		t_once();
		t_access_error();
		final_report();
	end
endmodule
